/* logic/ldcb_pkg.sv */
package ldcb_pkg;
  // chip-level indices that the bank depends on
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_PWR = 8'h22;
  // per-device indices
  localparam logic [7:0] IDX_ACT = 8'h30;
  localparam logic [7:0] IDX_CTL_LO = 8'h31;
  localparam logic [7:0] IDX_MEM_HI = 8'h5F;
  localparam logic [7:0] IDX_BHI = 8'h60;
  localparam logic [7:0] IDX_BLO = 8'h61;
  localparam logic [7:0] IDX_B2HI = 8'h62;
  localparam logic [7:0] IDX_B2LO = 8'h63;
  localparam logic [7:0] IDX_BASE_END = 8'h6F;
  localparam logic [7:0] IDX_IRQA = 8'h70;
  localparam logic [7:0] IDX_IRQA_GAP = 8'h71;
  localparam logic [7:0] IDX_IRQB = 8'h72;
  localparam logic [7:0] IDX_IRQB_GAP = 8'h73;
  localparam logic [7:0] IDX_DMA = 8'h74;
  localparam logic [7:0] IDX_DMA_GAP = 8'h75;
  localparam logic [7:0] IDX_UNIMP_LO = 8'h76;
  localparam logic [7:0] IDX_UNIMP_HI = 8'hDF;
  localparam logic [7:0] IDX_VEND_LO = 8'hE0;
  localparam logic [7:0] IDX_TOP = 8'hFF;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] DMA_RST = 8'h04;
  // logical device numbers
  localparam logic [2:0] LD_FLOPPY = 3'h0;
  localparam logic [2:0] LD_PAR = 3'h3;
  localparam logic [2:0] LD_SER1 = 3'h4;
  localparam logic [2:0] LD_SER2 = 3'h5;
  localparam logic [2:0] LD_KBD = 3'h7;
  localparam int NUM_LD = 8;
  // feature masks, one bit per logical device number
  localparam logic [7:0] BANK_MASK = 8'hB9;
  localparam logic [7:0] BASE_MASK = 8'h39;
  localparam logic [7:0] BASE2_MASK = 8'h20;
  localparam logic [7:0] DMA_MASK = 8'h29;
  localparam logic [7:0] IRQB_MASK = 8'h80;
  // power bits sit at the device number of their function
  localparam logic [7:0] PWR_MASK = 8'h39;
  // host decode window, low 12 address bits only
  localparam int DEC_BITS = 12;
  localparam logic [11:0] BASE_MIN = 12'h100;
  localparam logic [11:0] BASE_MAX8 = 12'hFF8;
  localparam logic [11:0] BASE_MAX4 = 12'hFFC;
  localparam logic [11:0] KBD_PORT0 = 12'h060;
  localparam logic [11:0] KBD_PORT1 = 12'h064;

  function automatic logic ldcb_has(input logic [7:0] m, input logic [7:0] ld);
    return (ld < 8'h08) && m[ld[2:0]];
  endfunction : ldcb_has
endpackage : ldcb_pkg

/* logic/ldcb_decode.sv */
`timescale 1ns/1ps
module ldcb_decode #(
  parameter int ALIGN = 8,
  parameter logic [11:0] MAXB = ldcb_pkg::BASE_MAX8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic active,
  input wire logic [15:0] base,
  input wire logic host_cyc,
  input wire logic [15:0] host_addr,
  output logic hit
);
  typedef struct packed {
    logic hit;
  } ldcb_dec_t;
  ldcb_dec_t s, n;
  logic valid;
  logic [11:0] amask;

  assign amask = ~(12'(ALIGN) - 12'h001);
  // out-of-range base parks this decoder only; a second base of the same device still decodes
  assign valid = (base[15:12] == 4'h0) && (base[11:0] >= ldcb_pkg::BASE_MIN) &&
                 (base[11:0] <= MAXB) && ((base[11:0] & ~amask) == 12'h000); // RULE18 RULE21

  always_comb begin
    n = s;
    // upper address bits never take part
    n.hit = host_cyc && active && valid &&
            ((host_addr[11:0] & amask) == base[11:0]); // RULE22 RULE23
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign hit = s.hit;

  a_hit_cause: assert property (@(posedge sys_clk) disable iff (rst) // RULE18
    hit |-> $past(active) && $past(valid) && $past(host_cyc))
    else $error("decode hit without active valid base");
endmodule : ldcb_decode

/* logic/ldcb_irq_route.sv */
`timescale 1ns/1ps
module ldcb_irq_route (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] dev_on,
  input wire logic [7:0] dev_irq,
  input wire logic kbd_irq_b,
  input wire logic [7:0][7:0] sel_a,
  input wire logic [7:0] sel_b,
  output logic [15:0] irq_line
);
  typedef struct packed {
    logic [15:0] line;
  } ldcb_irq_t;
  ldcb_irq_t s, n;

  // level 0 means no line; active-high so a rising request is a rising edge
  always_comb begin
    n = s;
    n.line = 16'h0000;
    for (int i = 0; i < ldcb_pkg::NUM_LD; i++) begin
      if (dev_on[i] && dev_irq[i] && (sel_a[i][3:0] != 4'h0)) begin
        n.line[sel_a[i][3:0]] = 1'b1; // RULE11
      end
    end
    if (dev_on[ldcb_pkg::LD_KBD] && kbd_irq_b && (sel_b[3:0] != 4'h0)) begin
      n.line[sel_b[3:0]] = 1'b1; // RULE10
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign irq_line = s.line;

  a_irq_route: assert property (@(posedge sys_clk) disable iff (rst) // RULE11
    dev_on[0] && dev_irq[0] && (sel_a[0][3:0] != 4'h0)
    |=> irq_line[$past(sel_a[0][3:0])])
    else $error("routed interrupt not raised");
endmodule : ldcb_irq_route

/* logic/ldcb_bank.sv */
`timescale 1ns/1ps
// Contract
// RULE1: one register bank per logical device, chosen by device number register.
// RULE2: host writes index port, then reads or writes data port.
// RULE3: bank registers reachable only in configuration state.
// RULE4: activate register bit 0 turns selected device on; rest reserved.
// RULE5: indices 0x31 to 0x5F ignore writes, read zero.
// RULE6: primary base is high byte at 0x60, low byte 0x61.
// RULE7: second base from 0x62 high and 0x63 low where used.
// RULE8: unused base registers 0x60 to 0x6F ignore writes, read zero.
// RULE9: every bank has interrupt select at 0x70, reset zero.
// RULE10: only keyboard bank has second interrupt select at 0x72.
// RULE11: routed interrupts default to rising-edge active-high.
// RULE12: 0x71, 0x73, 0x76 to 0xDF unimplemented, read zero.
// RULE13: dma select at 0x74, reset 0x04, floppy, second serial, parallel only.
// RULE14: 0x75 unimplemented in every bank.
// RULE15: 0xE0 to 0xFE vendor reserved, 0xFF reserved.
// RULE16: device on when activate bit or power bit is set.
// RULE17: writing activate or power bit updates the other.
// RULE18: base outside permitted range means host cycles ignored.
// RULE19: activate, base, interrupt selects reset to zero.
// RULE20: power register bits: 0 floppy, 3 parallel, 4 and 5 serial.
// RULE21: floppy and serial bases 0x100 to 0xFF8, eight-byte aligned.
// RULE22: base decode uses host address bits 11 to 0.
// RULE23: inactive device does not decode its base.
// RULE24: activate bits 7 to 1 read zero.
module ldcb_bank (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cfg_state,
  input wire logic idx_wr,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [7:0] wr_data,
  input wire logic host_cyc,
  input wire logic [15:0] host_addr,
  input wire logic [7:0] dev_irq,
  input wire logic kbd_irq_b,
  output logic [7:0] rd_data,
  output logic [7:0] dev_on,
  output logic [7:0] dev_hit,
  output logic sec_hit,
  output logic [7:0][15:0] dev_base,
  output logic [7:0][2:0] dma_chan,
  output logic [15:0] irq_line
);
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] ldn;
    logic [7:0] act;
    logic [7:0] pwr;
    logic [7:0][7:0] b_hi;
    logic [7:0][7:0] b_lo;
    logic [7:0] b2_hi;
    logic [7:0] b2_lo;
    logic [7:0][7:0] irq_a;
    logic [7:0] irq_b;
    logic [7:0][7:0] dma;
    logic [7:0] rd_data;
    logic [7:0] on;
    logic kbd_hit;
  } ldcb_bank_t;

  ldcb_bank_t s, n;
  logic [2:0] bk;
  logic bank_ok;
  logic has_base;
  logic has_b2;
  logic has_irqb;
  logic has_dma;
  logic cfg_wr;
  logic [7:0] rv;
  logic [7:0] reloc_hit;

  assign bk = s.ldn[2:0];
  assign bank_ok = ldcb_pkg::ldcb_has(ldcb_pkg::BANK_MASK, s.ldn); // RULE1
  assign has_base = ldcb_pkg::ldcb_has(ldcb_pkg::BASE_MASK, s.ldn); // RULE8
  assign has_b2 = ldcb_pkg::ldcb_has(ldcb_pkg::BASE2_MASK, s.ldn); // RULE7
  assign has_irqb = ldcb_pkg::ldcb_has(ldcb_pkg::IRQB_MASK, s.ldn); // RULE10
  assign has_dma = ldcb_pkg::ldcb_has(ldcb_pkg::DMA_MASK, s.ldn); // RULE13
  // no path touches the bank outside configuration state
  assign cfg_wr = cfg_state && data_wr; // RULE3

  // read mux for the register addressed by the index port
  always_comb begin
    rv = ldcb_pkg::RST_BYTE;
    case (s.idx)
      ldcb_pkg::IDX_LDN: rv = s.ldn;
      ldcb_pkg::IDX_PWR: rv = s.pwr;
      ldcb_pkg::IDX_ACT: begin
        if (bank_ok) begin
          rv = {7'h00, s.act[bk]}; // RULE4 RULE24
        end
      end
      ldcb_pkg::IDX_BHI: begin
        if (has_base) begin
          rv = s.b_hi[bk]; // RULE6
        end
      end
      ldcb_pkg::IDX_BLO: begin
        if (has_base) begin
          rv = s.b_lo[bk]; // RULE6
        end
      end
      ldcb_pkg::IDX_B2HI: begin
        if (has_b2) begin
          rv = s.b2_hi; // RULE7
        end
      end
      ldcb_pkg::IDX_B2LO: begin
        if (has_b2) begin
          rv = s.b2_lo; // RULE7
        end
      end
      ldcb_pkg::IDX_IRQA: begin
        if (bank_ok) begin
          rv = s.irq_a[bk]; // RULE9
        end
      end
      ldcb_pkg::IDX_IRQB: begin
        if (has_irqb) begin
          rv = s.irq_b; // RULE10
        end
      end
      ldcb_pkg::IDX_DMA: begin
        if (has_dma) begin
          rv = s.dma[bk]; // RULE13
        end
      end
      // reserved, unimplemented and vendor indices all read zero
      default: rv = ldcb_pkg::RST_BYTE; // RULE5 RULE12 RULE14 RULE15
    endcase
  end

  always_comb begin
    n = s;
    if (cfg_state && idx_wr) begin
      n.idx = wr_data; // RULE2
    end
    if (cfg_wr) begin
      case (s.idx)
        ldcb_pkg::IDX_LDN: n.ldn = wr_data; // RULE1
        ldcb_pkg::IDX_PWR: begin
          // power bits mirror into activate bits of the same device
          n.pwr = wr_data & ldcb_pkg::PWR_MASK; // RULE20
          n.act = (s.act & ~ldcb_pkg::PWR_MASK) | (wr_data & ldcb_pkg::PWR_MASK); // RULE17
        end
        ldcb_pkg::IDX_ACT: begin
          if (bank_ok) begin
            n.act[bk] = wr_data[0]; // RULE4
            if (ldcb_pkg::PWR_MASK[bk]) begin
              n.pwr[bk] = wr_data[0]; // RULE17
            end
          end
        end
        ldcb_pkg::IDX_BHI: begin
          if (has_base) begin
            n.b_hi[bk] = wr_data; // RULE6
          end
        end
        ldcb_pkg::IDX_BLO: begin
          if (has_base) begin
            n.b_lo[bk] = wr_data; // RULE6
          end
        end
        ldcb_pkg::IDX_B2HI: begin
          if (has_b2) begin
            n.b2_hi = wr_data; // RULE7
          end
        end
        ldcb_pkg::IDX_B2LO: begin
          if (has_b2) begin
            n.b2_lo = wr_data; // RULE7
          end
        end
        ldcb_pkg::IDX_IRQA: begin
          if (bank_ok) begin
            n.irq_a[bk] = wr_data; // RULE9
          end
        end
        ldcb_pkg::IDX_IRQB: begin
          if (has_irqb) begin
            n.irq_b = wr_data; // RULE10
          end
        end
        ldcb_pkg::IDX_DMA: begin
          if (has_dma) begin
            n.dma[bk] = wr_data; // RULE13
          end
        end
        // everything else drops the write
        // must not touch the index: an index write may share this cycle
        default: begin end // RULE5 RULE8 RULE12 RULE14 RULE15
      endcase
    end
    if (data_rd) begin
      n.rd_data = cfg_state ? rv : ldcb_pkg::RST_BYTE; // RULE3
    end
    n.on = n.act | n.pwr; // RULE16
    // keyboard ports are fixed, not relocatable
    n.kbd_hit = host_cyc && s.on[ldcb_pkg::LD_KBD] &&
                ((host_addr[11:0] == ldcb_pkg::KBD_PORT0) ||
                 (host_addr[11:0] == ldcb_pkg::KBD_PORT1)); // RULE22 RULE23
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0; // RULE19
      s.dma <= {8{ldcb_pkg::DMA_RST}}; // RULE13
    end else begin
      s <= n;
    end
  end

  // relocatable decoders; parallel port accepts four-byte alignment
  for (genvar i = 0; i < ldcb_pkg::NUM_LD; i++) begin : g_dec
    if (ldcb_pkg::BASE_MASK[i]) begin : g_on
      localparam int AL = (i == int'(ldcb_pkg::LD_PAR)) ? 4 : 8;
      localparam logic [11:0] MX = (i == int'(ldcb_pkg::LD_PAR)) ?
                                   ldcb_pkg::BASE_MAX4 : ldcb_pkg::BASE_MAX8;
      ldcb_decode #(.ALIGN(AL), .MAXB(MX)) u_dec (
        .sys_clk(sys_clk),
        .rst(rst),
        .active(s.on[i]),
        .base({s.b_hi[i], s.b_lo[i]}),
        .host_cyc(host_cyc),
        .host_addr(host_addr),
        .hit(reloc_hit[i])
      ); // RULE18 RULE21 RULE23
    end else begin : g_off
      assign reloc_hit[i] = 1'b0;
    end
  end

  ldcb_decode #(.ALIGN(8), .MAXB(ldcb_pkg::BASE_MAX8)) u_dec2 (
    .sys_clk(sys_clk),
    .rst(rst),
    .active(s.on[ldcb_pkg::LD_SER2]),
    .base({s.b2_hi, s.b2_lo}),
    .host_cyc(host_cyc),
    .host_addr(host_addr),
    .hit(sec_hit)
  ); // RULE7

  ldcb_irq_route u_irq (
    .sys_clk(sys_clk),
    .rst(rst),
    .dev_on(s.on),
    .dev_irq(dev_irq),
    .kbd_irq_b(kbd_irq_b),
    .sel_a(s.irq_a),
    .sel_b(s.irq_b),
    .irq_line(irq_line)
  ); // RULE11

  always_comb begin
    dev_hit = reloc_hit;
    dev_hit[ldcb_pkg::LD_KBD] = s.kbd_hit;
  end

  for (genvar i = 0; i < ldcb_pkg::NUM_LD; i++) begin : g_out
    assign dev_base[i] = {s.b_hi[i], s.b_lo[i]};
    assign dma_chan[i] = s.dma[i][2:0];
  end

  assign rd_data = s.rd_data;
  assign dev_on = s.on;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_cfg_gate: assert property (!cfg_state && data_wr |=> // RULE3
    $stable(s.act) && $stable(s.ldn) && $stable(s.b_hi) && $stable(s.irq_a))
    else $error("bank changed outside configuration state");

  a_idx_gate: assert property (!cfg_state && idx_wr |=> $stable(s.idx)) // RULE3
    else $error("index changed outside configuration state");

  a_cfg_read: assert property (!cfg_state && data_rd |=> rd_data == 8'h00) // RULE3
    else $error("read outside configuration state not zero");

  a_ldn_store: assert property (cfg_wr && s.idx == ldcb_pkg::IDX_LDN // RULE1
    |=> s.ldn == $past(wr_data))
    else $error("device number not stored");

  a_rsvd_low: assert property (cfg_state && data_rd && // RULE5
    (s.idx inside {[ldcb_pkg::IDX_CTL_LO:ldcb_pkg::IDX_MEM_HI]}) |=> rd_data == 8'h00)
    else $error("reserved index read not zero");

  a_act_rsvd: assert property (cfg_state && data_rd && s.idx == ldcb_pkg::IDX_ACT // RULE24
    |=> rd_data[7:1] == 7'h00)
    else $error("activate reserved bits not zero");

  a_act_on: assert property (cfg_wr && s.idx == ldcb_pkg::IDX_ACT && bank_ok && // RULE16
    wr_data[0] |=> dev_on[$past(bk)] ##1 dev_on[$past(bk, 2)])
    else $error("activated device not on");

  a_act_link: assert property (cfg_wr && s.idx == ldcb_pkg::IDX_ACT && bank_ok && // RULE17
    ldcb_pkg::PWR_MASK[bk] |=> s.pwr[$past(bk)] == $past(wr_data[0]))
    else $error("power bit not linked to activate");

  a_pwr_link: assert property (cfg_wr && s.idx == ldcb_pkg::IDX_PWR // RULE17
    |=> (s.act & ldcb_pkg::PWR_MASK) == ($past(wr_data) & ldcb_pkg::PWR_MASK))
    else $error("activate bits not linked to power");

  a_base_rb: assert property (cfg_wr && s.idx == ldcb_pkg::IDX_BHI && has_base // RULE6
    |=> dev_base[$past(bk)][15:8] == $past(wr_data))
    else $error("base high byte not stored");

  a_base_unused: assert property (cfg_state && data_rd && !has_base && // RULE8
    (s.idx inside {[ldcb_pkg::IDX_BHI:ldcb_pkg::IDX_BASE_END]}) |=> rd_data == 8'h00)
    else $error("unused base register not zero");

  a_irqa_store: assert property (cfg_wr && s.idx == ldcb_pkg::IDX_IRQA && bank_ok // RULE9
    |=> s.irq_a[$past(bk)] == $past(wr_data))
    else $error("interrupt select not stored");

  a_irqb_kbd: assert property (cfg_state && data_rd && s.idx == ldcb_pkg::IDX_IRQB && // RULE10
    !has_irqb |=> rd_data == 8'h00)
    else $error("second interrupt select outside keyboard bank");

  a_dma_only: assert property (cfg_state && data_rd && s.idx == ldcb_pkg::IDX_DMA && // RULE13
    !has_dma |=> rd_data == 8'h00)
    else $error("dma select outside its banks");

  a_dma_store: assert property (cfg_wr && s.idx == ldcb_pkg::IDX_DMA && has_dma // RULE13
    |=> dma_chan[$past(bk)] == $past(wr_data[2:0]))
    else $error("dma channel not stored");

  a_unimp_gap: assert property (cfg_state && data_rd && // RULE12
    ((s.idx == ldcb_pkg::IDX_IRQA_GAP) || (s.idx == ldcb_pkg::IDX_IRQB_GAP) ||
     (s.idx inside {[ldcb_pkg::IDX_UNIMP_LO:ldcb_pkg::IDX_UNIMP_HI]})) |=> rd_data == 8'h00)
    else $error("unimplemented index not zero");

  a_unimp_75: assert property (cfg_state && data_rd && s.idx == ldcb_pkg::IDX_DMA_GAP // RULE14
    |=> rd_data == 8'h00)
    else $error("index 0x75 not zero");

  a_vend_rsvd: assert property (cfg_state && data_rd && // RULE15
    (s.idx inside {[ldcb_pkg::IDX_VEND_LO:ldcb_pkg::IDX_TOP]}) |=> rd_data == 8'h00)
    else $error("vendor index not zero");

  a_kbd_hit: assert property (dev_hit[ldcb_pkg::LD_KBD] // RULE23
    |-> $past(s.on[ldcb_pkg::LD_KBD]))
    else $error("inactive keyboard decoded");
endmodule : ldcb_bank

/* test/ldcb_host_model.sv */
`timescale 1ns/1ps
module ldcb_host_model (
  input wire logic sys_clk,
  input wire logic [7:0] rd_data,
  output logic cfg_state,
  output logic idx_wr,
  output logic data_wr,
  output logic data_rd,
  output logic [7:0] wr_data
);
  initial begin
    cfg_state = 1'b1;
    idx_wr = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    wr_data = 8'h00;
  end

  // one strobe for one cycle; released bus shows the inverse, never stale data
  task automatic cyc(input logic [1:0] kind, input logic [7:0] val);
    @(posedge sys_clk);
    #2;
    idx_wr = (kind == 2'h0);
    data_wr = (kind == 2'h1);
    data_rd = (kind == 2'h2);
    wr_data = val;
    @(posedge sys_clk);
    #2;
    idx_wr = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    wr_data = ~val;
  endtask : cyc

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
    cyc(2'h0, idx);
    cyc(2'h1, val);
  endtask : wr_reg

  // read data is valid in the cycle after the taken edge
  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] val);
    cyc(2'h0, idx);
    cyc(2'h2, 8'h00);
    val = rd_data;
  endtask : rd_reg

  task automatic set_cfg(input logic v);
    @(posedge sys_clk);
    #2;
    cfg_state = v;
  endtask : set_cfg
endmodule : ldcb_host_model

/* test/logical_device_config_bank_tb.sv */
`timescale 1ns/1ps
module logical_device_config_bank_tb;
  logic sys_clk;
  logic rst;
  logic host_cyc;
  logic kbd_irq_b;
  logic [15:0] host_addr;
  logic [7:0] dev_irq;
  logic cfg_state;
  logic idx_wr;
  logic data_wr;
  logic data_rd;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] dev_on;
  logic [7:0] dev_hit;
  logic sec_hit;
  logic [7:0][15:0] dev_base;
  logic [7:0][2:0] dma_chan;
  logic [15:0] irq_line;
  int err_total = 0;
  int samples_checked = 0;
  logic [7:0] banks [5] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h07};
  logic [7:0] rsv [11] = '{8'h31, 8'h3F, 8'h5F, 8'h64, 8'h71, 8'h73, 8'h75, 8'h76,
    8'hDF, 8'hE0, 8'hFF};

  ldcb_bank uut (.sys_clk(sys_clk), .rst(rst), .cfg_state(cfg_state), .idx_wr(idx_wr),
    .data_wr(data_wr), .data_rd(data_rd), .wr_data(wr_data), .host_cyc(host_cyc),
    .host_addr(host_addr), .dev_irq(dev_irq), .kbd_irq_b(kbd_irq_b), .rd_data(rd_data),
    .dev_on(dev_on), .dev_hit(dev_hit), .sec_hit(sec_hit), .dev_base(dev_base),
    .dma_chan(dma_chan), .irq_line(irq_line));

  ldcb_host_model host (.sys_clk(sys_clk), .rd_data(rd_data), .cfg_state(cfg_state),
    .idx_wr(idx_wr), .data_wr(data_wr), .data_rd(data_rd), .wr_data(wr_data));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    host.rd_reg(idx, v);
    chk($sformatf("reg %h", idx), {8'h00, exp}, {8'h00, v});
  endtask : rchk

  task automatic sel(input logic [7:0] ld);
    host.wr_reg(8'h07, ld);
  endtask : sel

  // one host cycle, hit flags seen in the following cycle
  task automatic probe(input logic [15:0] a, input logic [7:0] hit, input logic sec);
    @(posedge sys_clk);
    #2;
    host_cyc = 1'b1;
    host_addr = a;
    @(posedge sys_clk);
    #2;
    host_cyc = 1'b0;
    host_addr = ~a;
    chk("dev_hit", {8'h00, hit}, {8'h00, dev_hit});
    chk("sec_hit", {15'h0000, sec}, {15'h0000, sec_hit});
  endtask : probe

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // a hang ends the run as a failure
  initial begin
    repeat (20000) @(posedge sys_clk);
    chk("watchdog", 16'h0000, 16'h0001);
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    host_cyc = 1'b0;
    host_addr = 16'h0000;
    dev_irq = 8'h00;
    kbd_irq_b = 1'b0;
    repeat (12) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    // reset values
    chk("dma_chan0", 16'h0004, {13'h0000, dma_chan[0]});
    chk("dev_on", 16'h0000, {8'h00, dev_on});
    sel(8'h00);
    rchk(8'h30, 8'h00);
    rchk(8'h60, 8'h00);
    rchk(8'h61, 8'h00);
    rchk(8'h70, 8'h00);
    rchk(8'h74, 8'h04);
    $display("test reset done");
    // per-bank features, expectation from which functions own which register
    foreach (banks[i]) begin
      sel(banks[i]);
      host.wr_reg(8'h60, 8'h12);
      host.wr_reg(8'h62, 8'h34);
      host.wr_reg(8'h72, 8'h0A);
      host.wr_reg(8'h74, 8'h02);
      rchk(8'h60, (banks[i] != 8'h07) ? 8'h12 : 8'h00);
      rchk(8'h62, (banks[i] == 8'h05) ? 8'h34 : 8'h00);
      rchk(8'h72, (banks[i] == 8'h07) ? 8'h0A : 8'h00);
      rchk(8'h74, (banks[i] == 8'h00 || banks[i] == 8'h03 || banks[i] == 8'h05) ?
        8'h02 : 8'h00);
    end
    chk("dma_chan0", 16'h0002, {13'h0000, dma_chan[0]});
    sel(8'h01);
    host.wr_reg(8'h30, 8'h01);
    rchk(8'h30, 8'h00);
    $display("test banks done");
    // reserved and unimplemented places in the fullest bank
    sel(8'h05);
    foreach (rsv[i]) host.wr_reg(rsv[i], 8'hA5);
    foreach (rsv[i]) rchk(rsv[i], 8'h00);
    $display("test reserved done");
    // activate and power linkage
    sel(8'h07);
    host.wr_reg(8'h30, 8'hFF);
    rchk(8'h30, 8'h01);
    host.wr_reg(8'h22, 8'hFF);
    rchk(8'h22, 8'h39);
    chk("dev_on", 16'h00B9, {8'h00, dev_on});
    sel(8'h03);
    rchk(8'h30, 8'h01);
    host.wr_reg(8'h30, 8'h00);
    rchk(8'h22, 8'h31);
    host.wr_reg(8'h22, 8'h00);
    chk("dev_on", 16'h0080, {8'h00, dev_on});
    $display("test activate done");
    // outside configuration state
    host.set_cfg(1'b0);
    host.wr_reg(8'h30, 8'h01);
    rchk(8'h30, 8'h00);
    host.set_cfg(1'b1);
    rchk(8'h30, 8'h00);
    $display("test cfg done");
    // interrupt routing, keyboard second select still 0x0A
    sel(8'h00);
    host.wr_reg(8'h70, 8'h06);
    host.wr_reg(8'h30, 8'h01);
    dev_irq = 8'h01;
    kbd_irq_b = 1'b1;
    repeat (2) @(posedge sys_clk);
    #2;
    chk("irq_line", 16'h0440, irq_line);
    dev_irq = 8'h00;
    kbd_irq_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    #2;
    chk("irq_line", 16'h0000, irq_line);
    $display("test irq done");
    // base decode; bank 0 is on with base 0x1200, outside its range
    sel(8'h04);
    host.wr_reg(8'h60, 8'h03);
    host.wr_reg(8'h61, 8'hF8);
    host.wr_reg(8'h30, 8'h01);
    chk("dev_base4", 16'h03F8, dev_base[4]);
    probe(16'h03F8, 8'h10, 1'b0);
    probe(16'h03FF, 8'h10, 1'b0);
    probe(16'h0400, 8'h00, 1'b0);
    probe(16'h53F8, 8'h10, 1'b0);
    probe(16'h1200, 8'h00, 1'b0);
    host.wr_reg(8'h61, 8'hFC);
    probe(16'h03FC, 8'h00, 1'b0);
    host.wr_reg(8'h61, 8'hF8);
    host.wr_reg(8'h30, 8'h00);
    probe(16'h03F8, 8'h00, 1'b0);
    sel(8'h05);
    host.wr_reg(8'h62, 8'h02);
    host.wr_reg(8'h63, 8'hE8);
    host.wr_reg(8'h30, 8'h01);
    probe(16'h02E8, 8'h00, 1'b1);
    // keyboard still on from the activate test, upper address bits ignored
    probe(16'hF064, 8'h80, 1'b0);
    // parallel port takes four-byte alignment
    sel(8'h03);
    host.wr_reg(8'h60, 8'h03);
    host.wr_reg(8'h61, 8'h7C);
    host.wr_reg(8'h30, 8'h01);
    probe(16'h037F, 8'h08, 1'b0);
    probe(16'h0380, 8'h00, 1'b0);
    $display("test decode done");
    // mid-run reset must return what the tests wrote to reset values, dma select back to 0x04
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    chk("dev_on", 16'h0000, {8'h00, dev_on});
    chk("dev_base3", 16'h0000, dev_base[3]);
    chk("dma_chan0", 16'h0004, {13'h0000, dma_chan[0]});
    $display("test rerun reset done");
    print_verdict();
  end
endmodule : logical_device_config_bank_tb
